// ==== design/rsc_pkg.sv ====
/*
 Shared constants for the relay switch channel control core: channel count,
 serial frame layout, command addresses, reset values, timing and modes.
 Assumes a single 40 MHz core clock.
*/
package rsc_pkg;

  localparam int NUM_CH = 8;
  localparam int FRAME_BITS = 16;
  localparam int CLK_FREQ_MHZ = 40;
  localparam int SCLK_MAX_MHZ = 5;

  // Limp-home restart time in microseconds and its length in core cycles
  localparam int RETRY_TIME_US = 1000;
  localparam int RETRY_CYCLES_DEF = RETRY_TIME_US * CLK_FREQ_MHZ;
  localparam int RETRY_W = 20;

  // Frame fields
  localparam int WR_BIT = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 12;
  localparam int DATA_MSB = 7;
  localparam logic [3:0] CNT_LAST = 4'hF;
  localparam logic [3:0] CNT_ZERO = 4'h0;

  // Command addresses
  localparam logic [2:0] ADR_CTRL = 3'h0;
  localparam logic [2:0] ADR_MAP0 = 3'h1;
  localparam logic [2:0] ADR_MAP1 = 3'h2;
  localparam logic [2:0] ADR_OLSRC = 3'h3;
  localparam logic [2:0] ADR_OVL_CLR = 3'h4;
  localparam logic [2:0] ADR_DIAG_CLR = 3'h5;
  localparam logic [2:0] ADR_DIAG = 3'h6;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MAP0_RST = 8'h04;
  localparam logic [7:0] MAP1_RST = 8'h08;
  localparam logic [7:0] OLSRC_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] RESP_RST = 16'h0000;
  localparam logic [15:0] RESP_ERR = 16'hFFFF;

  // Fixed limp-home routing
  localparam int LIMP_IN0_CH = 2;
  localparam int LIMP_IN1_CH = 3;

  // Synchroniser vector layout
  localparam int SYNC_W = 23;
  localparam logic [22:0] SYNC_RST = 23'h44_0000;
  localparam int SY_CSN = 22;
  localparam int SY_SCLK = 21;
  localparam int SY_SI = 20;
  localparam int SY_IDLE = 19;
  localparam int SY_VDD = 18;
  localparam int SY_IN0 = 17;
  localparam int SY_IN1 = 16;
  localparam int SY_OVL_MSB = 15;
  localparam int SY_OVL_LSB = 8;
  localparam int SY_OSM_MSB = 7;
  localparam int SY_OSM_LSB = 0;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_LIMP = 2'b01,
    MODE_IDLE = 2'b11
  } rsc_mode_type;

endpackage

// ==== design/rsc_sync3.sv ====
/*
 Three-stage input synchroniser with agreement filter.
 Assumes asynchronous inputs; output moves once stages two and three agree.
*/
`timescale 1ns/100ps
`default_nettype none
module rsc_sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] filt_q
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Per bit: take the new level only when the two later stages agree
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      filt_q <= RST_VAL;
    end else begin
      filt_q <= (filt_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
    end
  end

endmodule
`default_nettype wire

// ==== design/rsc_core.sv ====
/*
 Channel control core of an eight-channel high-side switch: 16-bit serial
 slave with daisy-chain pass-through, input mapping, limp-home routing,
 overload latch-off with restart, open-load source enable and diagnosis.
 Assumes all pins are asynchronous to core_clk and the serial clock stays
 well below a quarter of core_clk.
*/
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Serial output enable is low whenever chip select is high.
// - Chip select low selects; a high or pulled-up line means deselected.
// - Default and limp-home: input zero drives channel 2.
// - Default and limp-home: input one drives channel 3.
// - Limp-home ignores programmed mapping and uses the fixed routing.
// - Limp-home with idle low works without the digital supply.
// - In normal mode software maps each input to any set of channels.
// - Overload switches a channel off and latches it until software clears.
// - In limp-home a latched channel with input high restarts after retry time.
// - Sixteen-bit frames control channels and read back diagnosis.
// - Shifted data passes through for daisy chains, also with 8-bit parts.
// - Serial access works only while the digital supply is present.
// - Software enables the per-channel open-load test source while off.
// - Overload and open-load findings are latched and readable.
module rsc_core
  import rsc_pkg::*;
#(
  parameter int RETRY_CYCLES = RETRY_CYCLES_DEF
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic chip_select_low_n,
  input wire logic serial_clk,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  input wire logic idle_mode_req,
  input wire logic digital_supply_ok,
  input wire logic direct_input_zero,
  input wire logic direct_input_one,
  input wire logic [NUM_CH-1:0] overload_det,
  input wire logic [NUM_CH-1:0] output_monitor_status_bits,
  output logic [NUM_CH-1:0] channel_on,
  output logic [NUM_CH-1:0] open_load_test_source,
  output logic idle_mode,
  output logic limp_home
);

  ////////////////////////////////////////////////////////////////////////////
  logic [SYNC_W-1:0] raw_vec;
  logic [SYNC_W-1:0] syn_vec;
  logic csn_s, sclk_s, si_s, idle_s, vdd_s, in0_s, in1_s;
  logic [NUM_CH-1:0] ovl_s;
  logic [NUM_CH-1:0] osm_s;

  assign raw_vec = {chip_select_low_n, serial_clk, serial_in, idle_mode_req,
                    digital_supply_ok, direct_input_zero, direct_input_one,
                    overload_det, output_monitor_status_bits};

  rsc_sync3 #(.WIDTH(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .raw(raw_vec),
    .filt_q(syn_vec)
  );

  assign csn_s = syn_vec[SY_CSN];
  assign sclk_s = syn_vec[SY_SCLK];
  assign si_s = syn_vec[SY_SI];
  assign idle_s = syn_vec[SY_IDLE];
  assign vdd_s = syn_vec[SY_VDD];
  assign in0_s = syn_vec[SY_IN0];
  assign in1_s = syn_vec[SY_IN1];
  assign ovl_s = syn_vec[SY_OVL_MSB:SY_OVL_LSB];
  assign osm_s = syn_vec[SY_OSM_MSB:SY_OSM_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // Serial slave
  logic sel, sel_q, sclk_q, sclk_rise, sclk_fall;
  logic [FRAME_BITS-1:0] shift_q;
  logic [FRAME_BITS-1:0] resp_q;
  logic [3:0] bit_cnt_q;
  logic full_q, so_q;
  logic frame_end, frame_ok;

  assign sel = ~csn_s & vdd_s;
  assign sclk_rise = sclk_s & ~sclk_q;
  assign sclk_fall = ~sclk_s & sclk_q;
  assign frame_end = sel_q & ~sel;
  // Chains with 8-bit parts end on any byte boundary after the first full word
  assign frame_ok = frame_end & vdd_s & full_q & (bit_cnt_q[2:0] == CNT_ZERO[2:0]);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sel_q <= 1'b0;
      sclk_q <= 1'b0;
    end else begin
      sel_q <= sel;
      sclk_q <= sclk_s;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      shift_q <= RESP_RST;
      bit_cnt_q <= CNT_ZERO;
      full_q <= 1'b0;
      so_q <= 1'b0;
    end else if (sel && !sel_q) begin
      shift_q <= resp_q;
      bit_cnt_q <= CNT_ZERO;
      full_q <= 1'b0;
      so_q <= resp_q[FRAME_BITS-1];
    end else if (sel && sclk_rise) begin
      // Oldest bit leaves at the top, so data passes on down the chain
      shift_q <= {shift_q[FRAME_BITS-2:0], si_s};
      bit_cnt_q <= bit_cnt_q + 4'h1;
      if (bit_cnt_q == CNT_LAST) begin
        full_q <= 1'b1;
      end
    end else if (sel && sclk_fall) begin
      so_q <= shift_q[FRAME_BITS-1];
    end
  end

  assign serial_out = so_q;
  assign serial_out_oe = sel_q;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  logic wr;
  logic [2:0] addr;
  logic [7:0] data;
  logic [7:0] ctrl_q, map0_q, map1_q, olsrc_q;
  logic [NUM_CH-1:0] ovl_latch_q, ol_latch_q, retry_clr;
  logic [NUM_CH-1:0] ovl_clr_mask, diag_clr_mask;

  assign wr = frame_ok & shift_q[WR_BIT];
  assign addr = shift_q[ADDR_MSB:ADDR_LSB];
  assign data = shift_q[DATA_MSB:0];
  assign ovl_clr_mask = (wr && addr == ADR_OVL_CLR) ? data : BYTE_ZERO;
  assign diag_clr_mask = (wr && addr == ADR_DIAG_CLR) ? data : BYTE_ZERO;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= CTRL_RST;
      map0_q <= MAP0_RST;
      map1_q <= MAP1_RST;
      olsrc_q <= OLSRC_RST;
    end else if (wr) begin
      unique case (addr)
        ADR_CTRL: ctrl_q <= data;
        ADR_MAP0: map0_q <= data;
        ADR_MAP1: map1_q <= data;
        ADR_OLSRC: olsrc_q <= data;
        default: ;
      endcase
    end
  end

  function automatic logic [15:0] read_word(input logic [2:0] a,
      input logic [7:0] c, input logic [7:0] m0, input logic [7:0] m1,
      input logic [7:0] os, input logic [7:0] ov, input logic [7:0] ol);
    logic [15:0] r;
    r = {BYTE_ZERO, BYTE_ZERO};
    unique case (a)
      ADR_CTRL: r = {BYTE_ZERO, c};
      ADR_MAP0: r = {BYTE_ZERO, m0};
      ADR_MAP1: r = {BYTE_ZERO, m1};
      ADR_OLSRC: r = {BYTE_ZERO, os};
      default: r = {ov, ol};
    endcase
    return r;
  endfunction

  // Answer for the next frame: register read, standard diagnosis, or all ones after a bad frame
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      resp_q <= RESP_RST;
    end else if (frame_end && !frame_ok) begin
      resp_q <= RESP_ERR;
    end else if (wr) begin
      resp_q <= {ovl_latch_q, ol_latch_q};
    end else if (frame_ok) begin
      resp_q <= read_word(addr, ctrl_q, map0_q, map1_q, olsrc_q,
                          ovl_latch_q, ol_latch_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode and channel drive
  rsc_mode_type mode_d, mode_q;
  logic [NUM_CH-1:0] map_drv, limp_drv, ch_on_d, ch_on_q, ols_q;

  always_comb begin
    if (idle_s) begin
      mode_d = MODE_IDLE;
    end else if (!vdd_s) begin
      mode_d = MODE_LIMP;
    end else begin
      mode_d = MODE_NORMAL;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= MODE_NORMAL;
    end else begin
      mode_q <= mode_d;
    end
  end

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    assign map_drv[g] = (in0_s & map0_q[g]) | (in1_s & map1_q[g]);
    if (g == LIMP_IN0_CH) begin : g_l0
      assign limp_drv[g] = in0_s;
    end else if (g == LIMP_IN1_CH) begin : g_l1
      assign limp_drv[g] = in1_s;
    end else begin : g_ln
      assign limp_drv[g] = 1'b0;
    end
  end

  always_comb begin
    unique case (mode_q)
      MODE_NORMAL: ch_on_d = (ctrl_q | map_drv) & ~ovl_latch_q;
      MODE_LIMP: ch_on_d = limp_drv & ~ovl_latch_q;
      MODE_IDLE: ch_on_d = BYTE_ZERO;
      default: ch_on_d = BYTE_ZERO;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ch_on_q <= BYTE_ZERO;
      ols_q <= BYTE_ZERO;
    end else begin
      ch_on_q <= ch_on_d;
      ols_q <= olsrc_q & ~ch_on_d;
    end
  end

  assign channel_on = ch_on_q;
  assign open_load_test_source = ols_q;
  assign idle_mode = (mode_q == MODE_IDLE);
  assign limp_home = (mode_q == MODE_LIMP);

  ////////////////////////////////////////////////////////////////////////////
  // Overload latch, limp-home restart, open-load latch
  logic [RETRY_W-1:0] retry_cnt_q;
  logic [NUM_CH-1:0] retry_pend;
  logic retry_done;

  assign retry_pend = (mode_q == MODE_LIMP) ? (ovl_latch_q & limp_drv) : BYTE_ZERO;
  assign retry_done = (retry_cnt_q == RETRY_W'(RETRY_CYCLES - 1));
  assign retry_clr = retry_done ? retry_pend : BYTE_ZERO;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      retry_cnt_q <= '0;
    end else if (retry_pend == BYTE_ZERO || retry_done) begin
      retry_cnt_q <= '0;
    end else begin
      retry_cnt_q <= retry_cnt_q + 1'b1;
    end
  end

  // A new event wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ovl_latch_q <= BYTE_ZERO;
    end else begin
      ovl_latch_q <= (ovl_latch_q & ~(ovl_clr_mask | retry_clr))
                     | (ovl_s & ch_on_q);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ol_latch_q <= BYTE_ZERO;
    end else begin
      ol_latch_q <= (ol_latch_q & ~diag_clr_mask)
                    | (osm_s & ols_q & ~ch_on_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_SO_HIZ: assert property (csn_s |=> !serial_out_oe)
    else $error("serial output driven while deselected");
  AST_DESEL_HOLD: assert property (!sel && !sel_q |=> $stable(bit_cnt_q))
    else $error("bits counted while deselected");
  AST_LIMP_IN0: assert property (mode_q == MODE_LIMP && $stable(mode_q)
      |=> ch_on_q[LIMP_IN0_CH] == ($past(in0_s) & ~$past(ovl_latch_q[LIMP_IN0_CH])))
    else $error("input zero not routed to channel 2");
  AST_LIMP_IN1: assert property (mode_q == MODE_LIMP && $stable(mode_q)
      |=> ch_on_q[LIMP_IN1_CH] == ($past(in1_s) & ~$past(ovl_latch_q[LIMP_IN1_CH])))
    else $error("input one not routed to channel 3");
  AST_IDLE_OFF: assert property (idle_s |=> idle_mode ##1 channel_on == BYTE_ZERO)
    else $error("idle mode with a channel on");
  AST_LIMP_FIXED: assert property (mode_q == MODE_LIMP
      |=> (ch_on_q & ~(BYTE_ZERO | 8'h0C)) == BYTE_ZERO)
    else $error("mapping used in limp-home");
  AST_MAP: assert property (mode_q == MODE_NORMAL
      |=> ch_on_q == (($past(ctrl_q) | $past(map_drv)) & ~$past(ovl_latch_q)))
    else $error("programmed mapping not applied");
  AST_OVL_LATCH: assert property ((ovl_s & ch_on_q) != BYTE_ZERO
      |=> ((ovl_latch_q & $past(ovl_s & ch_on_q)) == $past(ovl_s & ch_on_q))
      ##1 ((ch_on_q & $past(ovl_s & ch_on_q, 2)) == BYTE_ZERO))
    else $error("overload did not latch the channel off");
  AST_RETRY: assert property (retry_done && retry_pend != BYTE_ZERO
      && (ovl_s & ch_on_q) == BYTE_ZERO
      |=> (ovl_latch_q & $past(retry_pend)) == BYTE_ZERO)
    else $error("limp-home restart missed");
  AST_FRAME: assert property (frame_ok |-> full_q
      && bit_cnt_q[2:0] == CNT_ZERO[2:0] && $past(sel))
    else $error("frame accepted without whole words");
  AST_NO_VDD: assert property (!vdd_s |=> !sel_q ##1 !frame_ok)
    else $error("serial access without digital supply");
  AST_OLS_OFF: assert property (1'b1 |=> ols_q == ($past(olsrc_q) & ~ch_on_q))
    else $error("open-load source wrong for channel state");
  AST_DIAG_HOLD: assert property (ol_latch_q != BYTE_ZERO && diag_clr_mask == BYTE_ZERO
      |=> (ol_latch_q & $past(ol_latch_q)) == $past(ol_latch_q))
    else $error("open-load finding lost");

  COV_FRAME: cover property (frame_ok && wr);
  COV_DAISY: cover property (frame_ok && $past(full_q, 20) && sel_q == 1'b1);
  COV_RETRY: cover property (retry_clr != BYTE_ZERO);
  COV_LIMP_ON: cover property (limp_home && channel_on[LIMP_IN0_CH]);

endmodule
`default_nettype wire

// ==== verif/rsc_spi_host.sv ====
/*
 Host controller model that masters the serial port of the channel control core.
 Assumes the bench resolves the released serial output to Z and that core_clk runs.
*/
`timescale 1ns/100ps
`default_nettype none
module rsc_spi_host (
  input wire logic core_clk,
  output logic chip_select_low_n,
  output logic serial_clk,
  output logic serial_in,
  input wire logic so_line
);
  // Idle: deselected, clock parked low, data at its pull-down level
  initial begin
    chip_select_low_n = 1'b1;
    serial_clk = 1'b0;
    serial_in = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // One frame, MSB first; half is the clock half period in core cycles
  task automatic xfer(input int nbits, input logic [31:0] tx, input int half,
                      output logic [31:0] rx);
    int i;
    rx = '0;
    @(posedge core_clk);
    chip_select_low_n <= 1'b0;
    repeat (half) @(posedge core_clk);
    for (i = nbits - 1; i >= 0; i--) begin
      serial_in <= tx[i];
      repeat (half) @(posedge core_clk);
      // Half period of at least 8 cycles keeps the clock at 2.5 MHz or below
      serial_clk <= 1'b1;
      rx = {rx[30:0], so_line};
      repeat (half) @(posedge core_clk);
      serial_clk <= 1'b0;
    end
    repeat (half) @(posedge core_clk);
    chip_select_low_n <= 1'b1;
    serial_in <= 1'b0;
    repeat (10) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// ==== verif/relay_switch_channel_control_test.sv ====
/*
 Self-checking bench for the channel control core with the host model on its port.
 Assumes a 40 MHz core clock and the short restart count of 20 cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module relay_switch_channel_control_test
  import rsc_pkg::*;
;
  logic core_clk, resetn, idle_mode_req, digital_supply_ok, in0, in1;
  logic [7:0] ovl_det, mon;
  wire logic cs_n, sclk, si, so_pin;
  logic serial_out, serial_out_oe, idle_mode, limp_home, oe_seen;
  logic [7:0] channel_on, ol_src;
  logic [31:0] rx;
  int err_total = 0, check_count = 0, cycles = 0;

  assign so_pin = serial_out_oe ? serial_out : 1'bz;

  rsc_core #(.RETRY_CYCLES(20)) DUT (.core_clk(core_clk), .resetn(resetn),
    .chip_select_low_n(cs_n), .serial_clk(sclk), .serial_in(si),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .idle_mode_req(idle_mode_req), .digital_supply_ok(digital_supply_ok),
    .direct_input_zero(in0), .direct_input_one(in1), .overload_det(ovl_det),
    .output_monitor_status_bits(mon), .channel_on(channel_on),
    .open_load_test_source(ol_src), .idle_mode(idle_mode), .limp_home(limp_home));
  rsc_spi_host host (.core_clk(core_clk), .chip_select_low_n(cs_n),
    .serial_clk(sclk), .serial_in(si), .so_line(so_pin));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (serial_out_oe === 1'b1) oe_seen <= 1'b1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      test_done();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_on(input logic [7:0] exp);
    int n;
    for (n = 0; n < 80 && channel_on !== exp; n++) @(posedge core_clk);
    check("channel_on", channel_on, exp);
  endtask

  task automatic wr(input logic [2:0] adr, input logic [7:0] d, output logic [31:0] r);
    host.xfer(16, {16'h0, 1'b1, adr, 4'h0, d}, 8, r);
  endtask

  task automatic rd(input logic [2:0] adr, output logic [31:0] r);
    host.xfer(16, {16'h0, 1'b0, adr, 12'h000}, 8, r);
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    resetn <= 1'b0;
    idle_mode_req <= 1'b0;
    digital_supply_ok <= 1'b1;
    in0 <= 1'b0;
    in1 <= 1'b0;
    ovl_det <= 8'h00;
    mon <= 8'h00;
    oe_seen <= 1'b0;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_default_route();
    do_reset();
    check("oe_idle", serial_out_oe, 1'b0);
    in0 <= 1'b1;
    chk_on(8'h04);
    in1 <= 1'b1;
    chk_on(8'h0C);
    $display("test default_route done");
  endtask

  task automatic t_frames();
    do_reset();
    wr(ADR_CTRL, 8'h05, rx);
    check("resp_after_reset", rx[15:0], 16'h0000);
    check("oe_in_frame", oe_seen, 1'b1);
    chk_on(8'h05);
    check("oe_after", serial_out_oe, 1'b0);
    rd(ADR_CTRL, rx);
    check("resp_write", rx[15:0], 16'h0000);
    rd(ADR_CTRL, rx);
    check("resp_read", rx[15:0], 16'h0005);
    host.xfer(8, 32'h0000_0081, 8, rx);
    chk_on(8'h05);
    rd(ADR_CTRL, rx);
    check("resp_bad", rx[15:0], 16'hFFFF);
    $display("test frames done");
  endtask

  task automatic t_daisy_map();
    do_reset();
    host.xfer(32, {16'hAB12, 1'b1, ADR_CTRL, 12'h003}, 12, rx);
    check("pass_through", rx[15:0], 16'hAB12);
    check("resp_head", rx[31:16], 16'h0000);
    chk_on(8'h03);
    host.xfer(24, {8'h00, 8'h5A, 1'b1, ADR_CTRL, 12'h00C}, 8, rx);
    check("pass_through_8", rx[7:0], 8'h5A);
    check("resp_24", rx[23:8], 16'h0000);
    chk_on(8'h0C);
    wr(ADR_CTRL, 8'h00, rx);
    wr(ADR_MAP0, 8'hF0, rx);
    in0 <= 1'b1;
    chk_on(8'hF0);
    wr(ADR_MAP1, 8'h11, rx);
    in1 <= 1'b1;
    chk_on(8'hF1);
    $display("test daisy_map done");
  endtask

  task automatic t_overload();
    do_reset();
    wr(ADR_CTRL, 8'h01, rx);
    chk_on(8'h01);
    ovl_det <= 8'h01;
    repeat (10) @(posedge core_clk);
    ovl_det <= 8'h00;
    repeat (30) @(posedge core_clk);
    check("latched_off", channel_on, 8'h00);
    rd(ADR_DIAG, rx);
    rd(ADR_DIAG, rx);
    check("ovl_diag", rx[15:0], 16'h0100);
    wr(ADR_OVL_CLR, 8'h01, rx);
    chk_on(8'h01);
    $display("test overload done");
  endtask

  task automatic t_open_load();
    do_reset();
    wr(ADR_OLSRC, 8'h80, rx);
    repeat (4) @(posedge core_clk);
    check("ol_source", ol_src, 8'h80);
    mon <= 8'h80;
    repeat (10) @(posedge core_clk);
    mon <= 8'h00;
    rd(ADR_DIAG, rx);
    rd(ADR_DIAG, rx);
    check("ol_diag", rx[15:0], 16'h0080);
    wr(ADR_CTRL, 8'h80, rx);
    chk_on(8'h80);
    check("ol_source_on", ol_src, 8'h00);
    wr(ADR_DIAG_CLR, 8'h80, rx);
    rd(ADR_DIAG, rx);
    check("ol_diag_before_clr", rx[15:0], 16'h0080);
    rd(ADR_DIAG, rx);
    check("ol_diag_clr", rx[15:0], 16'h0000);
    $display("test open_load done");
  endtask

  task automatic t_limp_idle();
    do_reset();
    wr(ADR_MAP0, 8'hF0, rx);
    in0 <= 1'b1;
    in1 <= 1'b1;
    digital_supply_ok <= 1'b0;
    chk_on(8'h0C);
    check("limp", limp_home, 1'b1);
    oe_seen <= 1'b0;
    wr(ADR_CTRL, 8'hFF, rx);
    check("no_serial", oe_seen, 1'b0);
    chk_on(8'h0C);
    ovl_det <= 8'h04;
    repeat (8) @(posedge core_clk);
    ovl_det <= 8'h00;
    repeat (4) @(posedge core_clk);
    check("limp_off", channel_on, 8'h08);
    chk_on(8'h0C);
    idle_mode_req <= 1'b1;
    chk_on(8'h00);
    check("idle", idle_mode, 1'b1);
    $display("test limp_idle done");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    resetn = 1'b0;
    idle_mode_req = 1'b0;
    digital_supply_ok = 1'b1;
    in0 = 1'b0;
    in1 = 1'b0;
    ovl_det = 8'h00;
    mon = 8'h00;
    oe_seen = 1'b0;
    t_default_route();
    t_frames();
    t_daisy_map();
    t_overload();
    t_open_load();
    t_limp_idle();
    test_done();
  end
endmodule
`default_nettype wire
